/* File: include/tpc_chan_if.sv */
// carrier between the control top and one capture channel
// assumes both ends share the one control clock
`timescale 1ns/1ps
interface tpc_chan_if #(parameter int POS_W = tpc_pkg::POS_WIDTH);
   logic en;
   logic update;
   logic rise_en;
   logic fall_en;
   logic trig;
   logic [POS_W-1:0] pos;
   logic rise_done;
   logic fall_done;
   logic [POS_W-1:0] rise_pos;
   logic [POS_W-1:0] fall_pos;
   modport ctl (
      output en, update, rise_en, fall_en, trig, pos,
      input rise_done, fall_done, rise_pos, fall_pos
   );
   modport chan (
      input en, update, rise_en, fall_en, trig, pos,
      output rise_done, fall_done, rise_pos, fall_pos
   );
endinterface

/* File: include/tpc_pkg.sv */
// touch-probe capture control: offsets, field positions, reset values
// assumes a single 200 MHz control clock and synchronous reset
package tpc_pkg;
   // object indices of the control, status and captured positions
   localparam logic [15:0] CTRL_INDEX = 16'h60B8;
   localparam logic [15:0] STATUS_INDEX = 16'h60B9;
   localparam logic [15:0] P1_RISE_INDEX = 16'h60BA;
   localparam logic [15:0] P1_FALL_INDEX = 16'h60BB;
   localparam logic [15:0] P2_RISE_INDEX = 16'h60BC;
   localparam logic [15:0] P2_FALL_INDEX = 16'h60BD;
   // channel field bases inside control and status words
   localparam int unsigned CH1_BASE = 0;
   localparam int unsigned CH2_BASE = 8;
   // control field offsets within a channel byte
   localparam int unsigned CTL_EN = 0;
   localparam int unsigned CTL_UPDATE = 1;
   localparam int unsigned CTL_SEL_Z = 2;
   localparam int unsigned CTL_RISE = 4;
   localparam int unsigned CTL_FALL = 5;
   // status field offsets within a channel byte
   localparam int unsigned ST_EN = 0;
   localparam int unsigned ST_RISE = 1;
   localparam int unsigned ST_FALL = 2;
   // writable control bits; all reserved bits read zero
   localparam logic [15:0] CTRL_MASK = 16'h3737;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [31:0] POS_RESET = 32'h0000_0000;
   localparam int unsigned POS_WIDTH = 32;
endpackage

/* File: rtl/tpc_chan.sv */
// one capture channel: edge detect, hold or overwrite, done flags
// assumes trig is already synchronised to clk
`timescale 1ns/1ps
module tpc_chan #(
   parameter int POS_W = tpc_pkg::POS_WIDTH
)(
   input wire logic clk,
   input wire logic rst_b,
   tpc_chan_if.chan ch
);
   logic prev;
   wire rise_hit = ch.en & ch.rise_en & ch.trig & ~prev;
   wire fall_hit = ch.en & ch.fall_en & ~ch.trig & prev;
   // RL2 hold or overwrite
   wire rise_take = rise_hit & (ch.update | ~ch.rise_done);
   wire fall_take = fall_hit & (ch.update | ~ch.fall_done);

   ////////////////////////////////////////////////////////////////////////
   // RL13 single edge detect
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         prev <= 1'b0;
      else
         prev <= ch.trig;
   end

   // RL10 rising capture store
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         ch.rise_pos <= POS_W'(tpc_pkg::POS_RESET);
      else if (rise_take)
         ch.rise_pos <= ch.pos;
   end

   // RL11 falling capture store
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         ch.fall_pos <= POS_W'(tpc_pkg::POS_RESET);
      else if (fall_take)
         ch.fall_pos <= ch.pos;
   end

   // RL9 detection flags, cleared while disabled
   always_ff @(posedge clk)
   begin
      if (!rst_b || !ch.en)
      begin
         ch.rise_done <= 1'b0;
         ch.fall_done <= 1'b0;
      end
      else
      begin
         ch.rise_done <= ch.rise_done | rise_hit;
         ch.fall_done <= ch.fall_done | fall_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_disabled_no_flag: assert property ( // RL1
      !ch.en |=> !ch.rise_done && !ch.fall_done)
      else $error("flag set while channel disabled");
   a_hold_first_rise: assert property ( // RL2
      ch.rise_done && !ch.update |=> $stable(ch.rise_pos))
      else $error("held rising position changed");
   a_update_rise_pos: assert property ( // RL10
      rise_hit && ch.update |=> ch.rise_pos == $past(ch.pos))
      else $error("rising capture not overwritten");
   a_rise_edge_gate: assert property ( // RL4
      !ch.rise_en || !ch.en |=> $stable(ch.rise_pos))
      else $error("rising capture while gated off");
   a_fall_edge_gate: assert property ( // RL7
      !ch.fall_en || !ch.en |=> $stable(ch.fall_pos))
      else $error("falling capture while gated off");
   a_fall_first_store: assert property ( // RL11
      fall_hit && !ch.fall_done
      |=> ch.fall_done && ch.fall_pos == $past(ch.pos))
      else $error("first falling capture lost");
   a_one_hit_edge: assert property ( // RL13
      rise_hit |=> !rise_hit ##1 !rise_hit)
      else $error("one edge gave repeated captures");

   c_rise_capture: cover property (rise_take);
   c_fall_capture: cover property (fall_take);
   c_held_second_edge: cover property (rise_hit && ch.rise_done && !ch.update);
endmodule

/* File: rtl/tpc_top.sv */
// touch-probe capture control: control word, triggers, status, positions
// assumes process-data writes synchronous to SYS_CLK; probe and Z pins are synchronised here
//
// Functional notes
// RL1: channel one works only when bit 0 set
// RL2: bits 1/9 choose hold-first or overwrite
// RL3: bit 2 picks probe one or Z index
// RL4: bits 4/5 enable channel one rising/falling
// RL5: channel two works only when bit 8 set
// RL6: bit 10 picks probe two or Z index
// RL7: bits 12/13 enable channel two edges
// RL8: master writes zero into reserved bits
// RL9: status mirrors enables and per-edge detections
// RL10: channel one rising position stored read-only
// RL11: channel one falling position stored read-only
// RL12: channel two keeps both edge positions
// RL13: triggers synchronised, one capture per edge
`timescale 1ns/1ps
module tpc_top #(
   parameter int POS_W = tpc_pkg::POS_WIDTH
)(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic CTRL_WR,
   input wire logic [15:0] CTRL_WDATA,
   input wire logic PROBE1_IN,
   input wire logic PROBE2_IN,
   input wire logic ZPHASE_IN,
   input wire logic [POS_W-1:0] POSITION,
   output logic [15:0] CTRL_WORD,
   output logic [15:0] STATUS_WORD,
   output logic [POS_W-1:0] P1_RISE_POS,
   output logic [POS_W-1:0] P1_FALL_POS,
   output logic [POS_W-1:0] P2_RISE_POS,
   output logic [POS_W-1:0] P2_FALL_POS
);
   generate
      if (POS_W < 2 || POS_W > 64)
      begin : g_bad_width
         $error("POS_W must lie in 2..64");
      end
   endgenerate

   function automatic logic ctl_bit(
      input logic [15:0] word,
      input int unsigned base,
      input int unsigned ofs
   );
      ctl_bit = word[base + ofs];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // control word
   logic [15:0] ctrl;
   // RL8 reserved bits forced zero
   wire [15:0] next_ctrl = CTRL_WDATA & tpc_pkg::CTRL_MASK;

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         ctrl <= tpc_pkg::CTRL_RESET;
      else if (CTRL_WR)
         ctrl <= next_ctrl;
   end
   assign CTRL_WORD = ctrl;

   ////////////////////////////////////////////////////////////////////////
   // RL13 two-flop synchronisers: probe1, probe2, Z index
   logic [2:0] sync1;
   logic [2:0] sync2;

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
      begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end
      else
      begin
         sync1 <= {ZPHASE_IN, PROBE2_IN, PROBE1_IN};
         sync2 <= sync1;
      end
   end

   wire probe1_s = sync2[0];
   wire probe2_s = sync2[1];
   wire zphase_s = sync2[2];

   ////////////////////////////////////////////////////////////////////////
   // channel one
   tpc_chan_if #(.POS_W(POS_W)) c1 ();
   // RL1 channel one enable
   assign c1.en = ctl_bit(ctrl, tpc_pkg::CH1_BASE, tpc_pkg::CTL_EN);
   assign c1.update = ctl_bit(ctrl, tpc_pkg::CH1_BASE, tpc_pkg::CTL_UPDATE);
   // RL3 channel one trigger select
   wire c1_sel_z = ctl_bit(ctrl, tpc_pkg::CH1_BASE, tpc_pkg::CTL_SEL_Z);
   assign c1.trig = c1_sel_z ? zphase_s : probe1_s;
   // RL4 channel one edge enables
   assign c1.rise_en = ctl_bit(ctrl, tpc_pkg::CH1_BASE, tpc_pkg::CTL_RISE);
   assign c1.fall_en = ctl_bit(ctrl, tpc_pkg::CH1_BASE, tpc_pkg::CTL_FALL);
   assign c1.pos = POSITION;

   tpc_chan #(.POS_W(POS_W)) u_chan1 (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .ch(c1.chan)
   );

   ////////////////////////////////////////////////////////////////////////
   // channel two
   tpc_chan_if #(.POS_W(POS_W)) c2 ();
   // RL5 channel two enable
   assign c2.en = ctl_bit(ctrl, tpc_pkg::CH2_BASE, tpc_pkg::CTL_EN);
   assign c2.update = ctl_bit(ctrl, tpc_pkg::CH2_BASE, tpc_pkg::CTL_UPDATE);
   // RL6 channel two trigger select
   wire c2_sel_z = ctl_bit(ctrl, tpc_pkg::CH2_BASE, tpc_pkg::CTL_SEL_Z);
   assign c2.trig = c2_sel_z ? zphase_s : probe2_s;
   // RL7 channel two edge enables
   assign c2.rise_en = ctl_bit(ctrl, tpc_pkg::CH2_BASE, tpc_pkg::CTL_RISE);
   assign c2.fall_en = ctl_bit(ctrl, tpc_pkg::CH2_BASE, tpc_pkg::CTL_FALL);
   assign c2.pos = POSITION;

   // RL12 channel two positions
   tpc_chan #(.POS_W(POS_W)) u_chan2 (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .ch(c2.chan)
   );

   assign P1_RISE_POS = c1.rise_pos;
   assign P1_FALL_POS = c1.fall_pos;
   assign P2_RISE_POS = c2.rise_pos;
   assign P2_FALL_POS = c2.fall_pos;

   ////////////////////////////////////////////////////////////////////////
   // RL9 status word assembly
   logic [15:0] next_status;

   always_comb
   begin
      next_status = tpc_pkg::STATUS_RESET;
      next_status[tpc_pkg::CH1_BASE + tpc_pkg::ST_EN] = c1.en;
      next_status[tpc_pkg::CH1_BASE + tpc_pkg::ST_RISE] = c1.rise_done;
      next_status[tpc_pkg::CH1_BASE + tpc_pkg::ST_FALL] = c1.fall_done;
      next_status[tpc_pkg::CH2_BASE + tpc_pkg::ST_EN] = c2.en;
      next_status[tpc_pkg::CH2_BASE + tpc_pkg::ST_RISE] = c2.rise_done;
      next_status[tpc_pkg::CH2_BASE + tpc_pkg::ST_FALL] = c2.fall_done;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (!RST_B)
         STATUS_WORD <= tpc_pkg::STATUS_RESET;
      else
         STATUS_WORD <= next_status;
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   // control word checks
   a_reserved_zero: assert property ( // RL8
      (CTRL_WORD & ~tpc_pkg::CTRL_MASK) == 16'h0000)
      else $error("reserved control bit set");

   a_ctrl_write: assert property ( // RL8
      CTRL_WR |=> CTRL_WORD == ($past(CTRL_WDATA) & tpc_pkg::CTRL_MASK))
      else $error("control write not stored masked");

   a_ctrl_steady: assert property ( // RL8
      !CTRL_WR |=> $stable(CTRL_WORD))
      else $error("control word changed without a write");

   // channel one checks
   a_chan1_disabled: assert property ( // RL1
      !ctrl[0] |=> $stable(P1_RISE_POS) && $stable(P1_FALL_POS))
      else $error("channel one captured while disabled");

   a_probe1_select: assert property ( // RL3
      !ctrl[2] && ctrl[0] && ctrl[4] && !c1.rise_done
      && probe1_s && !$past(probe1_s)
      |=> P1_RISE_POS == $past(POSITION))
      else $error("probe one edge not captured");

   a_z_select_one: assert property ( // RL3
      ctrl[2] && ctrl[0] && ctrl[4] && ctrl[1]
      && zphase_s && !$past(zphase_s)
      |=> P1_RISE_POS == $past(POSITION))
      else $error("Z index did not capture channel one");

   a_rise_gate1: assert property ( // RL4
      !(ctrl[0] && ctrl[4]) |=> $stable(P1_RISE_POS))
      else $error("channel one rising capture while gated");

   a_fall_gate1: assert property ( // RL4
      !(ctrl[0] && ctrl[5]) |=> $stable(P1_FALL_POS))
      else $error("channel one falling capture while gated");

   // channel two checks
   a_chan2_disabled: assert property ( // RL5
      !ctrl[8] |=> $stable(P2_RISE_POS) && $stable(P2_FALL_POS))
      else $error("channel two captured while disabled");

   a_probe2_capture: assert property ( // RL6
      !ctrl[10] && ctrl[8] && ctrl[12] && ctrl[9]
      && probe2_s && !$past(probe2_s)
      |=> P2_RISE_POS == $past(POSITION) ##1 STATUS_WORD[9])
      else $error("probe two edge not captured");

   a_z_fall_two: assert property ( // RL7
      ctrl[10] && ctrl[8] && ctrl[13] && ctrl[9]
      && !zphase_s && $past(zphase_s)
      |=> P2_FALL_POS == $past(POSITION) ##1 STATUS_WORD[10])
      else $error("channel two falling edge not captured");

   // status and synchroniser checks
   a_status_enable: assert property ( // RL9
      ##1 STATUS_WORD[8] == $past(ctrl[8])
      && STATUS_WORD[0] == $past(ctrl[0]))
      else $error("status enable not mirrored");

   a_status_clear: assert property ( // RL9
      !ctrl[0] |=> ##1 !STATUS_WORD[1] && !STATUS_WORD[2])
      else $error("channel one done flag kept while disabled");

   a_sync_delay: assert property ( // RL13
      $past(RST_B) && $past(RST_B, 2) |-> probe1_s == $past(PROBE1_IN, 2))
      else $error("probe one synchroniser latency wrong");

   c_both_enabled: cover property (c1.en && c2.en && c1.rise_en && c1.fall_en);
   c_status_done: cover property (STATUS_WORD[9] && STATUS_WORD[10]);
endmodule

/* File: testbench/tpc_master_model.sv */
// fieldbus master model: writes the control word as process data
// assumes the caller enters put_word between clock edges
`timescale 1ns/1ps
module tpc_master_model (
   input wire logic clk,
   output logic wr,
   output logic [15:0] wdata
);
   initial
   begin
      wr = 1'b0;
      wdata = 16'h0000;
   end
   // one-cycle strobe; raw lets a scenario break the reserved bits
   task automatic put_word(input logic [15:0] w, input bit raw);
      @(posedge clk);
      #1;
      wr = 1'b1;
      wdata = raw ? w : (w & tpc_pkg::CTRL_MASK);
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask
endmodule

/* File: testbench/tpc_top_bench.sv */
// self-checking bench for the touch-probe capture control top
// assumes tpc_pkg, tpc_chan_if, tpc_chan and tpc_top compiled first
`timescale 1ns/1ps
module tpc_top_bench;
   localparam logic [31:0] zero = 32'h0000_0000;
   logic clk, rst_b, wr;
   logic [15:0] wdata, ctrl_word, status_word;
   logic [2:0] trig;
   logic [31:0] pos, p1r, p1f, p2r, p2f;
   int failures = 0;
   int compares = 0;
   tpc_master_model mst (.clk(clk), .wr(wr), .wdata(wdata));
   tpc_top dut (
      .SYS_CLK(clk), .RST_B(rst_b), .CTRL_WR(wr), .CTRL_WDATA(wdata),
      .PROBE1_IN(trig[0]), .PROBE2_IN(trig[1]), .ZPHASE_IN(trig[2]),
      .POSITION(pos), .CTRL_WORD(ctrl_word), .STATUS_WORD(status_word),
      .P1_RISE_POS(p1r), .P1_FALL_POS(p1f),
      .P2_RISE_POS(p2r), .P2_FALL_POS(p2f)
   );
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_out(input logic [15:0] st, input logic [31:0] a,
                          input logic [31:0] b, input logic [31:0] c,
                          input logic [31:0] d);
      chk("status", {16'h0000, st}, {16'h0000, status_word});
      chk("p1_rise", a, p1r);
      chk("p1_fall", b, p1f);
      chk("p2_rise", c, p2r);
      chk("p2_fall", d, p2f);
   endtask
   // trigger high 4 cycles, low 5; position steady meanwhile
   task automatic pulse(input int s, input logic [31:0] p);
      pos = p;
      trig[s] = 1'b1;
      wt(4);
      trig[s] = 1'b0;
      wt(5);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("ctrl", {16'h0000, tpc_pkg::CTRL_RESET}, {16'h0000, ctrl_word});
      chk_out(tpc_pkg::STATUS_RESET, zero, zero, zero, zero);
   endtask
   task automatic t_mask();
      mst.put_word(16'hFFFF, 1'b1);
      chk("ctrl", 32'h0000_3737, {16'h0000, ctrl_word});
      wt(1);
      chk("status", 32'h0000_0101, {16'h0000, status_word});
      mst.put_word(16'h0000, 1'b0);
      wt(2);
   endtask
   task automatic t_ch1_hold();
      mst.put_word(16'h0011, 1'b0);
      pulse(0, 32'h1111_1111);
      chk_out(16'h0003, 32'h1111_1111, zero, zero, zero);
      pulse(0, 32'h2222_2222);
      pulse(2, 32'h3333_3333);
      chk_out(16'h0003, 32'h1111_1111, zero, zero, zero);
   endtask
   task automatic t_ch1_upd();
      mst.put_word(16'h0000, 1'b0);
      wt(2);
      mst.put_word(16'h0037, 1'b0);
      pulse(0, 32'h4444_4444);
      chk_out(16'h0001, 32'h1111_1111, zero, zero, zero);
      pulse(2, 32'h5555_5555);
      chk_out(16'h0007, 32'h5555_5555, 32'h5555_5555, zero, zero);
      pulse(2, 32'h6666_6666);
      chk_out(16'h0007, 32'h6666_6666, 32'h6666_6666, zero, zero);
   endtask
   task automatic t_ch2();
      mst.put_word(16'h0000, 1'b0);
      wt(2);
      mst.put_word(16'h1100, 1'b0);
      pulse(1, 32'h7777_7777);
      chk_out(16'h0300, 32'h6666_6666, 32'h6666_6666, 32'h7777_7777,
              zero);
      pulse(1, 32'h8888_8888);
      chk("p2_rise_held", 32'h7777_7777, p2r);
      mst.put_word(16'h1300, 1'b0);
      pulse(1, 32'h8888_8888);
      chk("p2_rise_upd", 32'h8888_8888, p2r);
      chk("status", 32'h0000_0300, {16'h0000, status_word});
      mst.put_word(16'h3700, 1'b0);
      pulse(2, 32'h9999_9999);
      chk_out(16'h0700, 32'h6666_6666, 32'h6666_6666, 32'h9999_9999,
              32'h9999_9999);
   endtask
   task automatic t_off();
      mst.put_word(16'h3636, 1'b0);
      wt(2);
      pulse(0, 32'hAAAA_AAAA);
      pulse(1, 32'hBBBB_BBBB);
      pulse(2, 32'hCCCC_CCCC);
      chk_out(16'h0000, 32'h6666_6666, 32'h6666_6666, 32'h9999_9999,
              32'h9999_9999);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_b = 1'b0;
      trig = 3'b000;
      pos = zero;
      wt(6);
      rst_b = 1'b1;
      t_reset();
      t_mask();
      t_ch1_hold();
      t_ch1_upd();
      t_ch2();
      t_off();
      close_out();
   end
   initial
   begin
      #20000;
      failures++;
      close_out();
   end
endmodule
